// ---- rtl/ccl_pkg.sv ----
// Constants shared by the composite clock codec and loopback block.
// Assumes a 20 MHz pclk and a byte-addressed APB register map.
package ccl_pkg;
	localparam logic [7:0] LOOP_CTRL_ADDR = 8'h20;
	localparam logic [7:0] LINE_CFG_ADDR  = 8'h24;
	localparam logic [7:0] STATUS_ADDR    = 8'h28;
	localparam logic [7:0] LOOP_CTRL_RST  = 8'h00;
	localparam logic [7:0] LINE_CFG_RST   = 8'h00;
	localparam int FAR_BIT        = 2;
	localparam int NEAR_BIT       = 3;
	localparam int JA_EN_BIT      = 0;
	localparam int MARK_MODE_BIT  = 1;
	localparam int ST_LOCK_BIT    = 0;
	localparam int ST_FS_BIT      = 1;
	localparam int CLK_HZ         = 20_000_000;
	localparam int BIT_HZ         = 64_000;
	localparam int BIT_CYCLES     = CLK_HZ / BIT_HZ;
	localparam int PULSE_CYCLES   = (BIT_CYCLES * 5) / 8;
	localparam int BITS_PER_FRAME = 8;
	localparam int FRAMES_PER_MARK = 20;
	localparam int FS_TIMEOUT     = BIT_CYCLES * (BITS_PER_FRAME + 1);
	localparam int JA_DEPTH       = 4;
endpackage : ccl_pkg

// ---- rtl/ccl_cc_tx.sv ----
// Composite clock transmit encoder: dual-rail AMI with frame violations.
// Assumes the frame sync input is synchronous to pclk.
`timescale 1ns/100ps
module ccl_cc_tx
	import ccl_pkg::*;
#(
	parameter int BITS  = BIT_CYCLES,
	parameter int PULSE = PULSE_CYCLES
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic mark_mode,
	input  wire logic fs_in,
	output logic      tx_pos,
	output logic      tx_neg,
	output logic      tx_clk,
	output logic      fs_present
);
	logic [8:0]  cyc_reg;
	logic [2:0]  bit_reg;
	logic [4:0]  frame_reg;
	logic        pol_reg;
	logic        fs_prev_reg;
	logic [11:0] fs_age_reg;
	logic        fs_rise;
	logic        start;
	logic        pol_next;
	logic [2:0]  bit_next;
	logic [4:0]  frame_next;

	assign fs_rise = fs_in & ~fs_prev_reg;
	assign start = fs_rise || (cyc_reg == 9'(BITS - 1));

	always_comb begin
		bit_next = fs_rise ? 3'h0 : bit_reg + 3'h1;
		frame_next = frame_reg;
		if (bit_next == 3'h0)
			frame_next = (frame_reg == 5'(FRAMES_PER_MARK - 1)) ?
				5'h00 : frame_reg + 5'h01;
		// Frame start repeats polarity unless this is the marker frame
		if (bit_next == 3'h0 && !(mark_mode && frame_next == 5'h00))
			pol_next = pol_reg;
		else
			pol_next = ~pol_reg;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cyc_reg <= 9'h000;
			bit_reg <= 3'h0;
			frame_reg <= 5'h00;
			pol_reg <= 1'b0;
		end else if (start) begin
			cyc_reg <= 9'h000;
			bit_reg <= bit_next;
			frame_reg <= frame_next;
			pol_reg <= pol_next;
		end else begin
			cyc_reg <= cyc_reg + 9'h001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_pos <= 1'b0;
			tx_neg <= 1'b0;
			tx_clk <= 1'b0;
		end else begin
			tx_pos <= (start || cyc_reg < 9'(PULSE - 1)) &&
				(start ? pol_next : pol_reg);
			tx_neg <= (start || cyc_reg < 9'(PULSE - 1)) &&
				!(start ? pol_next : pol_reg);
			tx_clk <= start || cyc_reg < 9'(BITS / 2 - 1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fs_prev_reg <= 1'b0;
			fs_age_reg <= 12'hFFF;
			fs_present <= 1'b0;
		end else begin
			fs_prev_reg <= fs_in;
			if (fs_rise)
				fs_age_reg <= 12'h000;
			else if (fs_age_reg != 12'hFFF)
				fs_age_reg <= fs_age_reg + 12'h001;
			fs_present <= fs_age_reg < 12'(FS_TIMEOUT);
		end
	end

	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_sync_align: assert property (fs_rise |=> cyc_reg == 9'h000 &&
		bit_reg == 3'h0)
		else $error("frame sync did not realign the transmitter");
	a_free_frame: assert property (start && bit_next == 3'h0 &&
		!mark_mode |=> pol_reg == $past(pol_reg))
		else $error("missing violation at frame start");
	a_one_rail: assert property (!(tx_pos && tx_neg))
		else $error("both transmit rails active");
	c_marker: cover property (start && mark_mode && frame_next == 5'h00 &&
		bit_next == 3'h0);
endmodule : ccl_cc_tx

// ---- rtl/ccl_cc_rx.sv ----
// Composite clock receive decoder: recovers 64k, 8k and 400 Hz timing.
// Assumes dual-rail pulse levels synchronous to pclk.
`timescale 1ns/100ps
module ccl_cc_rx
	import ccl_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic in_pos,
	input  wire logic in_neg,
	output logic      clk64,
	output logic      frame8k,
	output logic      marker400,
	output logic      locked
);
	logic       prev_reg;
	logic       last_pol_reg;
	logic       seen_reg;
	logic [2:0] cnt_reg;
	logic       start;
	logic       viol;
	logic       missing;

	assign start = (in_pos | in_neg) & ~prev_reg;
	assign viol = start && seen_reg && (in_pos == last_pol_reg);
	assign missing = start && !viol && locked &&
		cnt_reg == 3'(BITS_PER_FRAME - 1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_reg <= 1'b0;
			last_pol_reg <= 1'b0;
			seen_reg <= 1'b0;
			cnt_reg <= 3'h0;
			locked <= 1'b0;
		end else begin
			prev_reg <= in_pos | in_neg;
			if (start) begin
				last_pol_reg <= in_pos;
				seen_reg <= 1'b1;
				cnt_reg <= (viol || missing) ? 3'h0 : cnt_reg + 3'h1;
				if (viol)
					locked <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk64 <= 1'b0;
			frame8k <= 1'b0;
			marker400 <= 1'b0;
		end else begin
			clk64 <= in_pos | in_neg;
			frame8k <= viol || missing;
			marker400 <= missing;
		end
	end

	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_viol_frame: assert property (viol |=> frame8k && !marker400)
		else $error("violation not reported as frame");
	a_marker_gap: assert property (missing |=> marker400 && frame8k)
		else $error("missing violation not flagged");
	c_lock: cover property (viol && !locked);
endmodule : ccl_cc_rx

// ---- rtl/ccl_top.sv ----
// Composite clock codec with far-end and near-end loopback, APB slave.
// Assumes line pulses arrive as dual-rail levels synchronous to pclk.
`timescale 1ns/100ps
module ccl_top
	import ccl_pkg::*;
#(
	parameter int JA_STAGES = JA_DEPTH
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        receive_line_tip,
	input  wire logic        receive_line_ring,
	input  wire logic        transmit_frame_sync_input,
	output logic             tx_line_pos,
	output logic             tx_line_neg,
	output logic             transmit_clock_output,
	output logic             rx_clk64,
	output logic             rx_frame8k,
	output logic             rx_marker400
);
	logic [7:0] loopback_control_reg;
	logic [7:0] line_config_reg;
	logic       far_end_loopback;
	logic       near_end_loopback;
	logic       ja_enable;
	logic       mark_mode;
	logic       enc_pos;
	logic       enc_neg;
	logic       enc_clk;
	logic       fs_present;
	logic       rx_locked;
	logic       rx_in_pos;
	logic       rx_in_neg;
	logic       access;
	logic       setup;
	logic [JA_STAGES-1:0] ja_pos_reg;
	logic [JA_STAGES-1:0] ja_neg_reg;

	function automatic logic addr_known(input logic [7:0] a);
		return a == LOOP_CTRL_ADDR || a == LINE_CFG_ADDR ||
			a == STATUS_ADDR;
	endfunction : addr_known

	assign far_end_loopback = loopback_control_reg[FAR_BIT];
	assign near_end_loopback = loopback_control_reg[NEAR_BIT];
	assign ja_enable = line_config_reg[JA_EN_BIT];
	assign mark_mode = line_config_reg[MARK_MODE_BIT];
	assign setup = psel && !penable;
	assign access = psel && penable && pready;

	// APB: no wait states; read data and pready come from flops set in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= setup && !addr_known(paddr);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			case (paddr)
				LOOP_CTRL_ADDR: prdata <= {24'h00_0000, loopback_control_reg};
				LINE_CFG_ADDR:  prdata <= {24'h00_0000, line_config_reg};
				STATUS_ADDR:    prdata <= {30'h0, fs_present,
					rx_locked};
				default:        prdata <= 32'h0000_0000;
			endcase
		end else if (setup) begin
			prdata <= 32'h0000_0000;
		end
	end

	// Only the two enables are stored; unused bits read back as zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loopback_control_reg <= LOOP_CTRL_RST;
		end else if (access && pwrite && paddr == LOOP_CTRL_ADDR) begin
			loopback_control_reg <= pwdata[7:0] & 8'h0C;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_config_reg <= LINE_CFG_RST;
		end else if (access && pwrite && paddr == LINE_CFG_ADDR) begin
			line_config_reg <= pwdata[7:0] & 8'h03;
		end
	end

	ccl_cc_tx u_tx (
		.pclk       (pclk),
		.presetn    (presetn),
		.mark_mode  (mark_mode),
		.fs_in      (transmit_frame_sync_input),
		.tx_pos     (enc_pos),
		.tx_neg     (enc_neg),
		.tx_clk     (enc_clk),
		.fs_present (fs_present)
	);

	// Encoder output is dropped, not queued, while far-end loop is on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_line_pos <= 1'b0;
			tx_line_neg <= 1'b0;
		end else if (far_end_loopback) begin
			tx_line_pos <= receive_line_tip;
			tx_line_neg <= receive_line_ring;
		end else begin
			tx_line_pos <= enc_pos;
			tx_line_neg <= enc_neg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			transmit_clock_output <= 1'b0;
		else if (far_end_loopback)
			transmit_clock_output <= rx_clk64;
		else
			transmit_clock_output <= enc_clk;
	end

	// Jitter attenuator stand-in: fixed delay line on the looped data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ja_pos_reg <= '0;
			ja_neg_reg <= '0;
		end else begin
			ja_pos_reg <= {ja_pos_reg[JA_STAGES-2:0], tx_line_pos};
			ja_neg_reg <= {ja_neg_reg[JA_STAGES-2:0], tx_line_neg};
		end
	end

	always_comb begin
		if (!near_end_loopback) begin
			rx_in_pos = receive_line_tip;
			rx_in_neg = receive_line_ring;
		end else if (ja_enable) begin
			rx_in_pos = ja_pos_reg[JA_STAGES-1];
			rx_in_neg = ja_neg_reg[JA_STAGES-1];
		end else begin
			rx_in_pos = tx_line_pos;
			rx_in_neg = tx_line_neg;
		end
	end

	ccl_cc_rx u_rx (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_pos    (rx_in_pos),
		.in_neg    (rx_in_neg),
		.clk64     (rx_clk64),
		.frame8k   (rx_frame8k),
		.marker400 (rx_marker400),
		.locked    (rx_locked)
	);

	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Far-end loop: line data goes straight back out, one flop late
	a_far_retransmit: assert property (far_end_loopback |=>
		tx_line_pos == $past(receive_line_tip) &&
		tx_line_neg == $past(receive_line_ring))
		else $error("far-end loop did not retransmit line data");
	a_far_discard: assert property (far_end_loopback && enc_pos &&
		!receive_line_tip |=> !tx_line_pos)
		else $error("encoder data reached the line in far-end loop");
	a_far_neg_drop: assert property (far_end_loopback && enc_neg &&
		!receive_line_ring |=> !tx_line_neg)
		else $error("encoder negative rail reached the line");
	a_far_rx_line: assert property (far_end_loopback &&
		!near_end_loopback |-> rx_in_pos == receive_line_tip &&
		rx_in_neg == receive_line_ring)
		else $error("far-end loop starved the decoder");
	a_clk_out_far: assert property (far_end_loopback |=>
		transmit_clock_output == $past(rx_clk64))
		else $error("clock pin not carrying recovered clock");
	a_clk_out_norm: assert property (!far_end_loopback |=>
		transmit_clock_output == $past(enc_clk))
		else $error("clock pin not carrying transmit clock");

	// Normal transmit: encoder owns the line, never both rails at once
	a_normal_tx: assert property (!far_end_loopback |=>
		tx_line_pos == $past(enc_pos) &&
		tx_line_neg == $past(enc_neg))
		else $error("encoder output not on the line");
	a_line_one_rail: assert property (!far_end_loopback |=>
		!(tx_line_pos && tx_line_neg))
		else $error("both line rails driven");
	a_normal_rx: assert property (!near_end_loopback |->
		rx_in_pos == receive_line_tip &&
		rx_in_neg == receive_line_ring)
		else $error("decoder not fed from the line");

	// Near-end loop: decoder fed the sent rails, attenuator when enabled
	a_near_ja_path: assert property (near_end_loopback &&
		ja_enable && $stable(loopback_control_reg) |->
		rx_in_pos == $past(tx_line_pos, JA_STAGES) &&
		rx_in_neg == $past(tx_line_neg, JA_STAGES))
		else $error("near-end data skipped the attenuator");
	a_near_bypass: assert property (near_end_loopback &&
		!ja_enable |-> rx_in_pos == tx_line_pos &&
		rx_in_neg == tx_line_neg)
		else $error("near-end receive input not the sent data");
	a_near_still_tx: assert property (near_end_loopback &&
		!far_end_loopback |=> tx_line_pos == $past(enc_pos) &&
		tx_line_neg == $past(enc_neg))
		else $error("near-end loop disturbed transmission");
	a_ja_load: assert property (
		ja_pos_reg[0] == $past(tx_line_pos) &&
		ja_neg_reg[0] == $past(tx_line_neg))
		else $error("attenuator delay line not loading");

	// Register file: a write lands only at the access edge of its offset
	a_ctrl_unused: assert property (
		loopback_control_reg[1:0] == 2'h0 &&
		loopback_control_reg[7:4] == 4'h0)
		else $error("unused loopback bits stored");
	a_ctrl_write: assert property (access && pwrite &&
		paddr == LOOP_CTRL_ADDR |=>
		far_end_loopback == $past(pwdata[FAR_BIT]) &&
		near_end_loopback == $past(pwdata[NEAR_BIT]))
		else $error("loopback write not applied");
	a_ctrl_hold: assert property (!(access && pwrite &&
		paddr == LOOP_CTRL_ADDR) |=> $stable(loopback_control_reg))
		else $error("loopback control changed without a write");
	a_cfg_write: assert property (access && pwrite &&
		paddr == LINE_CFG_ADDR |=>
		ja_enable == $past(pwdata[JA_EN_BIT]) &&
		mark_mode == $past(pwdata[MARK_MODE_BIT]))
		else $error("line config write not applied");
	a_cfg_hold: assert property (!(access && pwrite &&
		paddr == LINE_CFG_ADDR) |=> $stable(line_config_reg))
		else $error("line config changed without a write");
	a_cfg_unused: assert property (line_config_reg[7:2] == 6'h00)
		else $error("unused line config bits stored");
	a_ctrl_read: assert property (setup && !pwrite &&
		paddr == LOOP_CTRL_ADDR |=>
		prdata == {24'h00_0000, $past(loopback_control_reg)})
		else $error("loopback control read back wrong");
	a_status_read: assert property (setup && !pwrite &&
		paddr == STATUS_ADDR |=>
		prdata == {30'h0, $past(fs_present), $past(rx_locked)})
		else $error("status read back wrong");

	// Bus answer: one access cycle, error only with the ready pulse
	a_apb_answer: assert property (setup |=> pready ##1 !pready)
		else $error("apb answer timing wrong");
	a_bad_addr: assert property (setup && !addr_known(paddr) |=> pslverr)
		else $error("unmapped address not refused");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error flagged outside the answer");
	a_ready_idle: assert property (!psel |=> !pready)
		else $error("ready raised without a request");
	a_rdata_hold: assert property (!setup |=> $stable(prdata))
		else $error("read data moved outside a setup");
	a_bad_write: assert property (access && pwrite && !addr_known(paddr)
		|=> $stable(line_config_reg) && $stable(loopback_control_reg))
		else $error("unmapped write changed a register");

	// Receiver outputs: a marker is always also a frame boundary
	a_marker_frame: assert property (rx_marker400 |-> rx_frame8k)
		else $error("marker without frame pulse");
	a_rx_clk: assert property (
		rx_clk64 == $past(rx_in_pos | rx_in_neg))
		else $error("recovered clock not following the pulses");

	c_far_loop: cover property (far_end_loopback && rx_frame8k);
	c_near_ja: cover property (near_end_loopback && ja_enable && rx_frame8k);
	c_marker: cover property (mark_mode && rx_marker400);
	c_status_read: cover property (access && !pwrite &&
		paddr == STATUS_ADDR);
endmodule : ccl_top

// ---- tb/ccl_line_model.sv ----
// Line model: composite clock AMI source driving the receive rails.
// Assumes a 20 MHz pclk; starts at marker frame 0 when run rises.
`timescale 1ns/100ps
module ccl_line_model
	import ccl_pkg::*;
(
	input  wire logic pclk,
	input  wire logic run,
	input  wire logic mark,
	output logic      tip  = 1'b0,
	output logic      ring = 1'b0
);
	int   cyc_reg;
	int   bit_reg;
	int   frm_reg;
	logic pol_reg = 1'b0;
	logic p;

	// Return-to-zero rails: both low between pulses, as on a real line
	always @(posedge pclk) begin
		if (!run) begin
			cyc_reg <= 0;
			bit_reg <= 0;
			frm_reg <= 0;
			tip     <= 1'b0;
			ring    <= 1'b0;
		end else begin
			if (cyc_reg == 0) begin
				p = (bit_reg == 0 && !(mark && frm_reg == 0)) ?
					pol_reg : !pol_reg;
				pol_reg <= p;
				tip     <= p;
				ring    <= !p;
			end else if (cyc_reg == PULSE_CYCLES) begin
				tip  <= 1'b0;
				ring <= 1'b0;
			end
			cyc_reg <= (cyc_reg == BIT_CYCLES - 1) ? 0 : cyc_reg + 1;
			if (cyc_reg == BIT_CYCLES - 1) begin
				bit_reg <= (bit_reg + 1) % BITS_PER_FRAME;
				if (bit_reg == BITS_PER_FRAME - 1)
					frm_reg <= (frm_reg + 1) % FRAMES_PER_MARK;
			end
		end
	end
endmodule : ccl_line_model

// ---- tb/tb.sv ----
// Testbench: APB register access, line traffic and loopback checks.
// Assumes ccl_top with default parameters and a 20 MHz pclk.
`timescale 1ns/100ps
`define CHK(name, exp, got) begin check_count++; if ((got) !== (exp)) begin \
	error_cnt++; $display("MISMATCH %s exp %h got %h", name, exp, got); end end
module tb
	import ccl_pkg::*;
;
	localparam int FRAME = BIT_CYCLES * BITS_PER_FRAME;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, fs = 1'b0, run = 1'b0, mark = 1'b1;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr, tip, ring, txp, txn, tco, c64, f8, m400;
	logic        tip_d, ring_d, c64_d, any_d, lastpol, st_viol, v;
	logic        mon = 1'b0;
	logic        gap_ok;
	logic [4:0]  hist;
	int          cyc, tv, rv, marks, gaps, st_cyc, c0;
	int          error_cnt, check_count;

	ccl_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .receive_line_tip(tip),
		.receive_line_ring(ring), .transmit_frame_sync_input(fs),
		.tx_line_pos(txp), .tx_line_neg(txn), .transmit_clock_output(tco),
		.rx_clk64(c64), .rx_frame8k(f8), .rx_marker400(m400));
	ccl_line_model line (.pclk(pclk), .run(run), .mark(mark), .tip(tip),
		.ring(ring));

	initial forever #25 pclk = ~pclk;

	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop

	// Ceiling well above the ~60k cycles the sequence needs
	always @(negedge pclk) begin
		cyc++;
		if (cyc == 80000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	// Edge-sampled monitor: sees pre-edge values of every output
	always @(posedge pclk) begin
		if ((txp | txn) && !any_d) begin
			v = (txp == lastpol);
			st_cyc = cyc;
			st_viol = v;
			lastpol = txp;
			if (mon && v) begin
				gap_ok = (cyc - tv == FRAME) || (cyc - tv == 2 * FRAME);
				if (tv > 0) `CHK("tx frame", 1'b1, gap_ok)
				gaps += (cyc - tv == 2 * FRAME);
				tv = cyc;
			end
		end
		if (mon && f8 === 1'b1) begin
			if (rv > 0) `CHK("rx frame", FRAME, cyc - rv)
			rv = cyc;
		end
		if (mon && m400 === 1'b1)
			marks++;
		tip_d = tip;
		ring_d = ring;
		c64_d = c64;
		hist = {hist[3:0], txp | txn};
		any_d = txp | txn;
	end

	// Holds the request until pready is seen high at a rising edge
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d, input logic [31:0] exp, input logic err);
		int n;
		n = 0;
		@(posedge pclk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		`CHK("access cycles", 1, n)
		if (!w) `CHK("prdata", exp, prdata)
		`CHK("pslverr", err, pslverr)
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(LOOP_CTRL_ADDR, 0, 0, 32'h0, 0);
		apb(LINE_CFG_ADDR, 0, 0, 32'h0, 0);
		apb(STATUS_ADDR, 0, 0, 32'h0, 0);
		apb(8'h30, 1, 32'hFF, 0, 1);
		apb(8'h30, 0, 0, 32'h0, 1);
		apb(LOOP_CTRL_ADDR, 1, 32'h0C, 0, 0);
		apb(LOOP_CTRL_ADDR, 0, 0, 32'h0C, 0);
		apb(LOOP_CTRL_ADDR, 1, 32'h00, 0, 0);
		apb(LINE_CFG_ADDR, 1, 32'h02, 0, 0);
		run <= 1'b1;
		mon = 1'b1;
		repeat (23 * FRAME + 20) @(posedge pclk);
		mon = 1'b0;
		`CHK("rx markers", 1, marks)
		`CHK("tx marker gap", 1'b1, gaps != 0)
		apb(STATUS_ADDR, 0, 0, 32'h01, 0);
		apb(LINE_CFG_ADDR, 1, 32'h00, 0, 0);
		// Raise sync while the rails are idle so a fresh pulse can start
		@(negedge (txp | txn));
		@(posedge pclk);
		fs <= 1'b1;
		c0 = cyc;
		repeat (6) @(posedge pclk);
		fs <= 1'b0;
		`CHK("fs align", 1'b1, ((st_cyc - c0) inside {[1:5]}) && st_viol)
		apb(STATUS_ADDR, 0, 0, 32'h03, 0);
		apb(LOOP_CTRL_ADDR, 1, 32'h04, 0, 0);
		repeat (4) @(posedge pclk);
		repeat (700) begin
			@(negedge pclk);
			`CHK("far pos", tip_d, txp)
			`CHK("far neg", ring_d, txn)
			`CHK("far rx", tip_d | ring_d, c64)
			if (c64 === c64_d) `CHK("far clk", c64, tco)
		end
		for (int ja = 0; ja < 2; ja++) begin
			apb(LINE_CFG_ADDR, 1, 32'(ja), 0, 0);
			apb(LOOP_CTRL_ADDR, 1, 32'h08, 0, 0);
			repeat (8) @(posedge pclk);
			repeat (700) begin
				@(negedge pclk);
				`CHK("near rx", ja ? hist[4] : hist[0], c64)
			end
		end
		apb(LOOP_CTRL_ADDR, 1, 32'h00, 0, 0);
		apb(LOOP_CTRL_ADDR, 0, 0, 32'h0, 0);
		report_and_stop();
	end
endmodule : tb
